// file: rtl/mbs_engine.sv
// telegram engine: parses requests from the spi link, runs them on the holding registers, answers
`timescale 1ns/10ps
module mbs_engine #(
    parameter int unsigned P_TIMEOUT_CYCLES = mbs_pkg::IDLE_TIMEOUT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic crc_enable,
    input wire logic app_ready,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe
);
    localparam logic [mbs_pkg::TMO_W-1:0] TMO_LAST = mbs_pkg::TMO_W'(P_TIMEOUT_CYCLES - 1);

    mbs_pkg::mbs_rx_t link_rx;
    logic [7:0] tx_byte_reg, tx_byte_next;
    logic sync1_reg, sync2_reg, sync3_reg;
    logic rx_event;
    logic [7:0] rx_b;

    mbs_pkg::mbs_state_t st_reg, st_next;
    mbs_pkg::mbs_phase_t ph_reg, ph_next;
    mbs_pkg::mbs_hdr_t hdr_reg, hdr_next, req;
    logic [7:0] fs_reg, fs_next, exc_reg, exc_next, hi_reg, hi_next, rb, exc_chk;
    logic [3:0] hdr_idx_reg, hdr_idx_next, hdr_last;
    logic [2:0] blk_reg, blk_next;
    logic [15:0] rem_reg, rem_next, crc_reg, crc_next, resp_cnt;
    logic [mbs_pkg::ADDR_W-1:0] ptr_reg, ptr_next;
    logic half_reg, half_next;
    logic [1:0] idx_reg, idx_next;
    logic [mbs_pkg::TMO_W-1:0] tmo_reg, tmo_next;
    logic req_done, payload_done, resp_tail;

    logic [15:0] mem [0:mbs_pkg::NUM_REGS-1];
    logic mem_we;
    logic [15:0] mem_wdata, mem_rdata;

    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < mbs_pkg::BYTE_W; i++)
            c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
        return c;
    endfunction

    // a read request carries only one address/count pair; move it to the read fields
    function automatic mbs_pkg::mbs_hdr_t hdr_norm(input logic [7:0] fs, input mbs_pkg::mbs_hdr_t h);
        mbs_pkg::mbs_hdr_t r;
        r = h;
        if (fs == mbs_pkg::FS_READ)
        begin
            r.rd_addr = h.wr_addr;
            r.rd_cnt = h.wr_cnt;
        end
        return r;
    endfunction

    function automatic logic [7:0] pair_fault(input logic [15:0] a, input logic [15:0] c);
        logic [7:0] code;
        code = mbs_pkg::EXC_NONE;
        if (c < mbs_pkg::CNT_MIN || c > mbs_pkg::CNT_MAX)
            code = mbs_pkg::EXC_ILLEGAL_VALUE;
        else if (a > mbs_pkg::LAST_REG_ADDR || ({1'b0, a} + {1'b0, c}) > mbs_pkg::REG_END)
            code = mbs_pkg::EXC_ILLEGAL_ADDRESS;
        return code;
    endfunction

    function automatic logic [7:0] hdr_fault(input logic [7:0] fs, input mbs_pkg::mbs_hdr_t r);
        logic [7:0] code;
        code = mbs_pkg::EXC_NONE;
        if (fs != mbs_pkg::FS_WRITE)
            code = pair_fault(r.rd_addr, r.rd_cnt);
        if (code == mbs_pkg::EXC_NONE && fs != mbs_pkg::FS_READ)
            code = pair_fault(r.wr_addr, r.wr_cnt);
        return code;
    endfunction

    mbs_spi_link u_link (
        .spi_clk(spi_clk),
        .rst(rst),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .tx_byte(tx_byte_reg),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .rx(link_rx)
    );

    // byte event crosses as a toggle; the data byte stays put for a whole byte time
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end
        else if (ce)
        begin
            sync1_reg <= link_rx.toggle;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign rx_event = sync2_reg ^ sync3_reg;
    assign rx_b = link_rx.data;
    assign mem_rdata = mem[ptr_reg];
    assign hdr_last = (fs_reg == mbs_pkg::FS_RDWR) ? mbs_pkg::HDR_LAST_LONG : mbs_pkg::HDR_LAST_SHORT;

    always_comb
    begin
        st_next = st_reg;
        ph_next = ph_reg;
        hdr_next = hdr_reg;
        fs_next = fs_reg;
        exc_next = exc_reg;
        hi_next = hi_reg;
        hdr_idx_next = hdr_idx_reg;
        blk_next = blk_reg;
        rem_next = rem_reg;
        crc_next = crc_reg;
        ptr_next = ptr_reg;
        half_next = half_reg;
        idx_next = idx_reg;
        tx_byte_next = tx_byte_reg;
        tmo_next = (st_reg == mbs_pkg::ST_IDLE || rx_event) ? '0 : tmo_reg + 1'b1;
        req = hdr_norm(fs_reg, hdr_reg);
        resp_cnt = (fs_reg == mbs_pkg::FS_WRITE) ? req.wr_cnt : req.rd_cnt;
        exc_chk = mbs_pkg::EXC_NONE;
        rb = mbs_pkg::FILLER;
        mem_we = 1'b0;
        mem_wdata = {hi_reg, rx_b};
        req_done = 1'b0;
        payload_done = 1'b0;
        resp_tail = 1'b0;
        if (st_reg != mbs_pkg::ST_IDLE && !rx_event && tmo_reg == TMO_LAST)
        begin
            st_next = mbs_pkg::ST_IDLE;
            tx_byte_next = mbs_pkg::FILLER;
        end
        else if (rx_event)
        begin
            blk_next = blk_reg + 3'h1;
            crc_next = crc_step(crc_reg, rx_b);
            case (st_reg)
                mbs_pkg::ST_IDLE:
                begin
                    blk_next = blk_reg;
                    crc_next = crc_reg;
                    // zero is no selector; pad bytes between telegrams are dropped
                    if (rx_b != mbs_pkg::FILLER)
                    begin
                        fs_next = rx_b;
                        crc_next = crc_step(mbs_pkg::CRC_INIT, rx_b);
                        blk_next = mbs_pkg::BLK_AFTER_FIRST;
                        hdr_idx_next = 4'h0;
                        exc_next = mbs_pkg::EXC_NONE;
                        st_next = mbs_pkg::ST_HDR;
                        if (!(rx_b == mbs_pkg::FS_READ || rx_b == mbs_pkg::FS_WRITE || rx_b == mbs_pkg::FS_RDWR)
                            || !app_ready)
                        begin
                            exc_next = mbs_pkg::EXC_ILLEGAL_FUNCTION;
                            crc_next = mbs_pkg::CRC_INIT;
                            st_next = mbs_pkg::ST_WAIT;
                            ph_next = mbs_pkg::PH_HEAD;
                            idx_next = 2'h0;
                        end
                    end
                end
                mbs_pkg::ST_HDR:
                begin
                    hdr_next = mbs_pkg::mbs_hdr_t'(mbs_pkg::HDR_W'({hdr_reg, rx_b}));
                    hdr_idx_next = hdr_idx_reg + 4'h1;
                    if (hdr_idx_reg == hdr_last)
                    begin
                        req = hdr_norm(fs_reg, hdr_next);
                        exc_chk = hdr_fault(fs_reg, req);
                        exc_next = exc_chk;
                        ptr_next = mbs_pkg::ADDR_W'(req.wr_addr);
                        rem_next = req.wr_cnt;
                        half_next = 1'b0;
                        if (exc_chk != mbs_pkg::EXC_NONE)
                            req_done = 1'b1;
                        else if (fs_reg == mbs_pkg::FS_READ)
                            payload_done = 1'b1;
                        else
                            st_next = mbs_pkg::ST_DATA;
                    end
                end
                mbs_pkg::ST_DATA:
                begin
                    half_next = ~half_reg;
                    if (!half_reg)
                        hi_next = rx_b;
                    else
                    begin
                        mem_we = 1'b1;
                        ptr_next = ptr_reg + 1'b1;
                        rem_next = rem_reg - 16'h0001;
                        if (rem_reg == mbs_pkg::CNT_MIN)
                            payload_done = 1'b1;
                    end
                end
                mbs_pkg::ST_CHECK:
                begin
                    half_next = 1'b1;
                    if (half_reg)
                    begin
                        if (crc_next == mbs_pkg::CRC_RESIDUE)
                            req_done = 1'b1;
                        else
                            st_next = mbs_pkg::ST_IDLE;
                    end
                end
                mbs_pkg::ST_WAIT:
                begin
                    crc_next = crc_reg;
                    if (blk_reg == mbs_pkg::BLK_LAST)
                        st_next = mbs_pkg::ST_RESP;
                end
                mbs_pkg::ST_RESP:
                begin
                    blk_next = blk_reg;
                    case (ph_reg)
                        mbs_pkg::PH_HEAD:
                        begin
                            idx_next = idx_reg + 2'h1;
                            if (idx_reg == 2'h0)
                                rb = (exc_reg != mbs_pkg::EXC_NONE) ? (fs_reg | mbs_pkg::EXC_FLAG) : fs_reg;
                            else if (exc_reg != mbs_pkg::EXC_NONE)
                            begin
                                rb = exc_reg;
                                resp_tail = 1'b1;
                            end
                            else if (idx_reg == 2'h1)
                                rb = 8'(resp_cnt >> mbs_pkg::BYTE_W);
                            else
                            begin
                                rb = 8'(resp_cnt);
                                ptr_next = mbs_pkg::ADDR_W'(req.rd_addr);
                                rem_next = req.rd_cnt;
                                half_next = 1'b0;
                                if (fs_reg == mbs_pkg::FS_WRITE)
                                    resp_tail = 1'b1;
                                else
                                    ph_next = mbs_pkg::PH_WORDS;
                            end
                        end
                        mbs_pkg::PH_WORDS:
                        begin
                            half_next = ~half_reg;
                            rb = half_reg ? 8'(mem_rdata) : 8'(mem_rdata >> mbs_pkg::BYTE_W);
                            if (half_reg)
                            begin
                                ptr_next = ptr_reg + 1'b1;
                                rem_next = rem_reg - 16'h0001;
                                if (rem_reg == mbs_pkg::CNT_MIN)
                                    resp_tail = 1'b1;
                            end
                        end
                        default:
                        begin
                            idx_next = idx_reg + 2'h1;
                            rb = (idx_reg == 2'h0) ? 8'(crc_reg) : 8'(crc_reg >> mbs_pkg::BYTE_W);
                            if (idx_reg != 2'h0)
                            begin
                                st_next = mbs_pkg::ST_FLUSH;
                                idx_next = 2'h0;
                            end
                        end
                    endcase
                    crc_next = (ph_reg == mbs_pkg::PH_CRC) ? crc_reg : crc_step(crc_reg, rb);
                    tx_byte_next = rb;
                end
                mbs_pkg::ST_FLUSH:
                begin
                    // two more bytes push the last answer byte through the link pipeline
                    tx_byte_next = mbs_pkg::FILLER;
                    idx_next = idx_reg + 2'h1;
                    if (idx_reg == mbs_pkg::FLUSH_LAST)
                        st_next = mbs_pkg::ST_IDLE;
                end
                default:
                    st_next = mbs_pkg::ST_IDLE;
            endcase
            if (payload_done)
            begin
                if (crc_enable)
                begin
                    st_next = mbs_pkg::ST_CHECK;
                    half_next = 1'b0;
                end
                else
                    req_done = 1'b1;
            end
            if (req_done)
            begin
                st_next = (blk_reg == mbs_pkg::BLK_LAST) ? mbs_pkg::ST_RESP : mbs_pkg::ST_WAIT;
                ph_next = mbs_pkg::PH_HEAD;
                idx_next = 2'h0;
                crc_next = mbs_pkg::CRC_INIT;
            end
            if (resp_tail)
            begin
                idx_next = 2'h0;
                if (crc_enable)
                    ph_next = mbs_pkg::PH_CRC;
                else
                    st_next = mbs_pkg::ST_FLUSH;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_reg <= mbs_pkg::ST_IDLE;
            ph_reg <= mbs_pkg::PH_HEAD;
            hdr_reg <= '0;
            fs_reg <= mbs_pkg::FILLER;
            exc_reg <= mbs_pkg::EXC_NONE;
            hi_reg <= mbs_pkg::FILLER;
            hdr_idx_reg <= 4'h0;
            blk_reg <= 3'h0;
            rem_reg <= 16'h0000;
            crc_reg <= mbs_pkg::CRC_INIT;
            ptr_reg <= '0;
            half_reg <= 1'b0;
            idx_reg <= 2'h0;
            tx_byte_reg <= mbs_pkg::FILLER;
            tmo_reg <= '0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
            ph_reg <= ph_next;
            hdr_reg <= hdr_next;
            fs_reg <= fs_next;
            exc_reg <= exc_next;
            hi_reg <= hi_next;
            hdr_idx_reg <= hdr_idx_next;
            blk_reg <= blk_next;
            rem_reg <= rem_next;
            crc_reg <= crc_next;
            ptr_reg <= ptr_next;
            half_reg <= half_next;
            idx_reg <= idx_next;
            tx_byte_reg <= tx_byte_next;
            tmo_reg <= tmo_next;
        end
    end

    // holding registers have no reset: contents survive a protocol restart
    always_ff @(posedge clk_sys)
    begin
        if (ce && mem_we)
            mem[ptr_reg] <= mem_wdata;
    end
endmodule

// file: rtl/mbs_pkg.sv
// shared constants and types of the spi telegram engine
package mbs_pkg;
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned IDLE_TIMEOUT_MS = 1000;
    localparam int unsigned IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_MS * (CLK_FREQ_HZ / MS_PER_S);
    localparam int unsigned TMO_W = 27;

    localparam int unsigned BYTE_W = 8;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [2:0] BLK_LAST = 3'h7;
    localparam logic [2:0] BLK_AFTER_FIRST = 3'h1;

    localparam logic [7:0] FS_READ = 8'h03;
    localparam logic [7:0] FS_WRITE = 8'h10;
    localparam logic [7:0] FS_RDWR = 8'h17;
    localparam logic [7:0] FILLER = 8'h00;

    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

    localparam int unsigned NUM_REGS = 5000;
    localparam int unsigned ADDR_W = 13;
    localparam logic [15:0] LAST_REG_ADDR = 16'h1387;
    localparam logic [16:0] REG_END = 17'h01388;
    localparam logic [15:0] CNT_MIN = 16'h0001;
    localparam logic [15:0] CNT_MAX = 16'h01f8;

    localparam logic [3:0] HDR_LAST_SHORT = 4'h3;
    localparam logic [3:0] HDR_LAST_LONG = 4'h7;

    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    localparam logic [1:0] FLUSH_LAST = 2'h1;

    typedef struct packed {
        logic [7:0] data;
        logic toggle;
    } mbs_rx_t;

    typedef struct packed {
        logic [15:0] rd_addr;
        logic [15:0] rd_cnt;
        logic [15:0] wr_addr;
        logic [15:0] wr_cnt;
    } mbs_hdr_t;

    localparam int unsigned HDR_W = $bits(mbs_hdr_t);

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HDR = 3'h1,
        ST_DATA = 3'h3,
        ST_CHECK = 3'h2,
        ST_WAIT = 3'h6,
        ST_RESP = 3'h7,
        ST_FLUSH = 3'h5
    } mbs_state_t;

    typedef enum logic [1:0] {
        PH_HEAD = 2'h0,
        PH_WORDS = 2'h1,
        PH_CRC = 2'h3
    } mbs_phase_t;
endpackage

// file: rtl/mbs_spi_link.sv
// spi slave byte shifter running on the link clock (mode 3, msb first)
`timescale 1ns/10ps
module mbs_spi_link (
    input wire logic spi_clk,
    input wire logic rst,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [7:0] tx_byte,
    output logic spi_miso,
    output logic spi_miso_oe,
    output mbs_pkg::mbs_rx_t rx
);
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [6:0] shift_reg, shift_next;
    logic [7:0] tx_cur_reg, tx_cur_next;
    mbs_pkg::mbs_rx_t rx_reg, rx_next;
    logic miso_reg, miso_next;

    always_comb
    begin
        bit_cnt_next = bit_cnt_reg + 3'h1;
        shift_next = {shift_reg[5:0], spi_mosi};
        rx_next = rx_reg;
        tx_cur_next = tx_cur_reg;
        miso_next = tx_cur_reg[mbs_pkg::BYTE_LAST_BIT - bit_cnt_reg];
        if (bit_cnt_reg == mbs_pkg::BYTE_LAST_BIT)
        begin
            // tx_byte was set by the system side a whole byte earlier, so it is stable here
            rx_next.data = {shift_reg, spi_mosi};
            rx_next.toggle = ~rx_reg.toggle;
            tx_cur_next = tx_byte;
        end
    end

    // chip select high restarts byte alignment; the next frame starts at bit 7
    // reset clears it too, so the first frame after power-up is aligned even if select never rose
    always_ff @(posedge spi_clk or posedge spi_cs_n or posedge rst)
    begin
        if (spi_cs_n || rst)
            bit_cnt_reg <= 3'h0;
        else
            bit_cnt_reg <= bit_cnt_next;
    end

    always_ff @(posedge spi_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_reg <= '0;
            tx_cur_reg <= mbs_pkg::FILLER;
            shift_reg <= 7'h00;
        end
        else
        begin
            rx_reg <= rx_next;
            tx_cur_reg <= tx_cur_next;
            shift_reg <= shift_next;
        end
    end

    // output changes on the falling edge so the master samples a settled bit
    always_ff @(negedge spi_clk or posedge rst)
    begin
        if (rst)
            miso_reg <= 1'b0;
        else
            miso_reg <= miso_next;
    end

    assign spi_miso = miso_reg & ~spi_cs_n;
    assign spi_miso_oe = ~spi_cs_n;
    assign rx = rx_reg;
endmodule

// file: test/mbs_engine_assertions.sv
// pin-level checker for the spi telegram engine
`timescale 1ns/10ps
module mbs_engine_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic crc_enable,
    input wire logic app_ready,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence clk_hold;
        (spi_clk && !spi_cs_n) [*3];
    endsequence
    sequence cs_idle;
        spi_cs_n [*3];
    endsequence
    oe_cs_a: assert property (spi_miso_oe == !spi_cs_n)
        else $error("miso enable differs from select");
    miso_quiet_a: assert property (spi_cs_n |-> !spi_miso)
        else $error("miso high while deselected");
    bit_steady_a: assert property ((spi_clk && $past(spi_clk) && !spi_cs_n && !$past(spi_cs_n)) |-> $stable(spi_miso))
        else $error("miso moved while link clock high");
    hold_steady_a: assert property (clk_hold |-> $stable(spi_miso))
        else $error("miso moved inside a high phase");
    drop_oe_a: assert property ($rose(spi_cs_n) |-> !spi_miso_oe && !spi_miso)
        else $error("miso not released on deselect");
    take_oe_a: assert property ($fell(spi_cs_n) |-> spi_miso_oe)
        else $error("miso not driven on select");
    idle_run_a: assert property (cs_idle |=> !spi_miso || !spi_cs_n)
        else $error("miso active between bytes");
    rst_quiet_a: assert property (disable iff (1'b0) (rst && spi_cs_n) |=> (!spi_miso || !spi_cs_n))
        else $error("miso active in reset");
endmodule
bind mbs_engine mbs_engine_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .crc_enable(crc_enable),
    .app_ready(app_ready), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe));

// file: test/mbs_host_model.sv
// spi master model for the link side of the engine
`timescale 1ns/10ps
module mbs_host_model (
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic spi_miso_oe
);
    logic last_bit = 1'b0;
    // undriven line shows the inverse of its last level
    wire wire_lvl = spi_miso_oe ? spi_miso : !last_bit;
    initial
    begin
        spi_clk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end
    // clock runs only inside a byte, idle high; gap stretches the byte spacing
    task automatic xfer(input logic [7:0] tx, input int gap, output logic [7:0] rx);
        spi_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #40 spi_clk = 1'b0;
            spi_mosi = tx[i];
            #40 spi_clk = 1'b1;
            rx[i] = wire_lvl;
            last_bit = wire_lvl;
        end
        #40 spi_cs_n = 1'b1;
        spi_mosi = !spi_mosi;
        #(43.3 + gap);
    endtask
endmodule

// file: test/mbs_engine_tb.sv
// self-checking bench for the spi telegram engine
`timescale 1ns/10ps
module mbs_engine_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b0;
    logic crc_enable = 1'b0;
    logic app_ready = 1'b1;
    wire spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    int n_errors = 0;
    int checked = 0;
    int seed = 32'hfe0791c7;
    logic [15:0] mem [0:4999];
    logic [7:0] q[$];
    logic [7:0] e[$];
    always #4 clk_sys = !clk_sys;
    mbs_engine #(.P_TIMEOUT_CYCLES(2000)) u_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .crc_enable(crc_enable),
        .app_ready(app_ready), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));
    mbs_host_model u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i])
        begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // one telegram: model it, pad to a block, poll, compare every returned byte
    task automatic run(input logic [7:0] fs, input int a, input int c, input int wa, input int wc);
        logic [7:0] x;
        logic [15:0] k;
        int ex;
        int n;
        q = {fs, 8'(a >> 8), 8'(a), 8'(c >> 8), 8'(c)};
        if (fs == 8'h17) q = {q, 8'(wa >> 8), 8'(wa), 8'(wc >> 8), 8'(wc)};
        ex = 0;
        if (!(fs inside {8'h03, 8'h10, 8'h17}) || !app_ready) ex = 1;
        else if (c < 1 || c > 504) ex = 3;
        else if (a + c > 5000) ex = 2;
        if (ex != 0) e = {fs | 8'h80, 8'(ex)};
        else e = {fs, 8'(c >> 8), 8'(c)};
        if (ex == 0)
        begin
            for (int i = 0; i < wc; i++)
            begin
                k = 16'($random(seed));
                mem[wa + i] = k;
                q = {q, k[15:8], k[7:0]};
            end
            if (fs != 8'h10) for (int i = 0; i < c; i++) e = {e, mem[a + i][15:8], mem[a + i][7:0]};
        end
        if (crc_enable)
        begin
            k = crc16(q);
            q = {q, k[7:0], k[15:8]};
            k = crc16(e);
            e = {e, k[7:0], k[15:8]};
        end
        n = (q.size() + 7) / 8 * 8;
        for (int i = 0; i < n + e.size() + 4; i++)
        begin
            u_host.xfer(i < q.size() ? q[i] : (i < n ? 8'($random(seed)) : 8'h00), $random(seed) & 15, x);
            chk("miso byte", x, (i >= n + 2 && i < n + 2 + e.size()) ? e[i - n - 2] : 8'h00);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        int a;
        int c;
        logic [7:0] x;
        // a real rising edge on reset is needed to clear the link-side flops
        #1 rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        run(8'h10, 4997, 3, 4997, 3);
        run(8'h03, 4997, 3, 0, 0);
        run(8'h17, 4998, 2, 4998, 2);
        for (int i = 0; i < 3; i++)
        begin
            a = {$random(seed)} % 4990;
            c = 1 + {$random(seed)} % 4;
            run(8'h10, a, c, a, c);
            run(8'h03, a, c, 0, 0);
        end
        run(8'h03, 100, 0, 0, 0);
        run(8'h03, 100, 505, 0, 0);
        run(8'h10, 4999, 2, 4999, 2);
        run(8'h04, 0, 1, 0, 0);
        @(posedge clk_sys);
        #1 app_ready = 1'b0;
        run(8'h03, 0, 1, 0, 0);
        @(posedge clk_sys);
        #1 app_ready = 1'b1;
        crc_enable = 1'b1;
        run(8'h17, 4997, 3, 4990, 2);
        run(8'h03, 4990, 2, 0, 0);
        run(8'h04, 0, 1, 0, 0);
        @(posedge clk_sys);
        #1 crc_enable = 1'b0;
        // an abandoned request must be dropped after the quiet time
        u_host.xfer(8'h10, 0, x);
        u_host.xfer(8'h00, 0, x);
        repeat (2100) @(posedge clk_sys);
        run(8'h03, 4997, 3, 0, 0);
        conclude();
    end
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_errors++;
        conclude();
    end
endmodule
